// ### logic/ctrl_port_defines.svh
// Register offsets, field positions, reset values, the two-wire identifier and the four-wire header size.
`ifndef CTRL_PORT_DEFINES_SVH
`define CTRL_PORT_DEFINES_SVH

`define REG_FOUR_WIRE_CFG   16'h0008
`define REG_TWO_WIRE_CFG    16'h0009
`define REG_ADDR_ERR        16'h000a
`define REG_PAD_CTRL_TWO    16'h0c21

`define DRIVE_STYLE_BIT     4
`define STEP_MSB            1
`define STEP_LSB            0
`define PULLDOWN_BIT        0
`define ADDR_ERR_BIT        0

`define FOUR_WIRE_CFG_RST   16'h0011
`define TWO_WIRE_CFG_RST    16'h0001
`define PAD_CTRL_TWO_RST    16'h0001

`define TWO_WIRE_ID_HIGH    6'h1a
`define FOUR_WIRE_HDR_BITS  16

`endif

// ### logic/ctrl_port_pkg.sv
// Types and shared decoding of the control port front end.
`default_nettype none
`include "ctrl_port_defines.svh"

package ctrl_port_pkg;

   typedef logic [15:0] word_t;

   typedef enum logic [1:0] {PORT_TWO, PORT_FOUR, PORT_THIRD, PORT_NONE} port_t;

   typedef enum logic [2:0] {
      TW_IDLE, TW_ID, TW_ADDR_HI, TW_ADDR_LO, TW_DATA_HI, TW_DATA_LO, TW_READ_HI, TW_READ_LO
   } tw_state_t;

   // Tells whether an address names a register of the map.
   function automatic logic addr_valid(input word_t a);
      return (a == `REG_FOUR_WIRE_CFG) || (a == `REG_TWO_WIRE_CFG) ||
             (a == `REG_ADDR_ERR) || (a == `REG_PAD_CTRL_TWO);
   endfunction

   // Advances an address by the selected step; a step of zero holds it.
   function automatic word_t step_addr(input word_t a, input logic [1:0] s);
      return a + {14'h0000, s};
   endfunction

endpackage

`default_nettype wire

// ### logic/four_wire_ctrl_port.sv
// Four-wire serial port shifter running on the host's serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "ctrl_port_defines.svh"

module four_wire_ctrl_port (
   // Link side
   input  wire logic                  sclk_in,
   input  wire logic                  select_n_in,
   input  wire logic                  mosi_in,
   output logic                      miso_out,
   output logic                      miso_oe_n_out,
   // Core side
   input  wire logic                  rst_n_in,
   input  wire logic                  wired_or_in,
   input  wire logic [1:0]            step_in,
   input  wire ctrl_port_pkg::word_t  rdata_in,
   output logic                      req_toggle_out,
   output logic                      req_we_out,
   output ctrl_port_pkg::word_t      req_addr_out,
   output ctrl_port_pkg::word_t      req_wdata_out
);
   import ctrl_port_pkg::*;

   logic [3:0] bit_cnt_reg;
   logic       in_data_reg;
   logic       read_reg;
   logic       step_due_reg;
   word_t      shift_reg;
   word_t      tx_reg;
   word_t      word_next;
   logic [2:0] cfg_meta_reg;
   logic [2:0] cfg_reg;

   assign word_next = {shift_reg[14:0], mosi_in};

   // --------------------
   // Configuration brought into this clock
   // --------------------
   always_ff @(posedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_meta_reg <= 3'h5;
         cfg_reg      <= 3'h5;
      end else begin
         cfg_meta_reg <= {wired_or_in, step_in};
         cfg_reg      <= cfg_meta_reg;
      end
   end

   // --------------------
   // Frame bit counter and input shifter
   // --------------------
   always_ff @(posedge sclk_in or posedge select_n_in) begin
      if (select_n_in) begin
         bit_cnt_reg <= 4'h0;
         in_data_reg <= 1'b0;
         shift_reg   <= 16'h0000;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         shift_reg   <= word_next;
         if (bit_cnt_reg == 4'hf) begin
            in_data_reg <= 1'b1;
         end
      end
   end

   // --------------------
   // Requests towards the register map
   // --------------------
   always_ff @(posedge sclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_toggle_out <= 1'b0;
         req_we_out     <= 1'b0;
         req_addr_out   <= 16'h0000;
         req_wdata_out  <= 16'h0000;
         read_reg       <= 1'b0;
         step_due_reg   <= 1'b0;
      end else if (!select_n_in && bit_cnt_reg == 4'hf) begin
         if (!in_data_reg) begin
            read_reg     <= word_next[15];
            req_addr_out <= {1'b0, word_next[14:0]};
            step_due_reg <= 1'b0;
            if (word_next[15]) begin
               req_we_out     <= 1'b0;
               req_toggle_out <= ~req_toggle_out;
            end
         end else if (read_reg) begin
            req_addr_out   <= step_addr(req_addr_out, cfg_reg[1:0]);
            req_toggle_out <= ~req_toggle_out;
         end else begin
            if (step_due_reg) begin
               req_addr_out <= step_addr(req_addr_out, cfg_reg[1:0]);
            end
            step_due_reg   <= 1'b1;
            req_we_out     <= 1'b1;
            req_wdata_out  <= word_next;
            req_toggle_out <= ~req_toggle_out;
         end
      end
   end

   // --------------------
   // Output driver, changed on the falling edge
   // --------------------
   always_ff @(negedge sclk_in or posedge select_n_in) begin
      if (select_n_in) begin
         miso_out      <= 1'b0;
         miso_oe_n_out <= 1'b1;
         tx_reg        <= 16'h0000;
      end else if (in_data_reg && read_reg) begin
         miso_oe_n_out <= 1'b0;
         if (bit_cnt_reg == 4'h0) begin
            miso_out <= rdata_in[15];
            tx_reg   <= {rdata_in[14:0], 1'b0};
         end else begin
            miso_out <= tx_reg[15];
            tx_reg   <= {tx_reg[14:0], 1'b0};
         end
      end else begin
         miso_out      <= 1'b0;
         miso_oe_n_out <= cfg_reg[2];
      end
   end

endmodule // four_wire_ctrl_port

`default_nettype wire

// ### logic/control_port_access_front_end.sv
// Control port front end: two-wire, four-wire and third-bus access to the register map.
`timescale 1ns/1ps
`default_nettype none
`include "ctrl_port_defines.svh"

// Summary of operation
// - Every register reads back its contents.
// - Ports work without the core system clock.
// - Map accesses commit on the control clock.
// - All ports served while system clock runs.
// - Clock stopped: first requesting port owns access.
// - Clock restarted: ownership released for all ports.
// - Every access that is not refused has its address checked.
// - Invalid address raises address-error output.
// - Two-wire port: data, clock, address select.
// - Four-wire port: select low frames accesses.
// - Drive-style bit: four-wire output released or driven low during header and write words; read data always driven.
// - Four-wire address step 0 to 3.
// - Two-wire address step 0 to 3.
// - Pad bit enables address-select pull-down.
// - Either port reaches the whole map.
// - Two-wire identifier chosen by address select.
// - Four-wire address advances every word.
module control_port_access_front_end (
   // Control clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  clk_en_in,
   input  wire logic                  core_system_clock_active_in,
   // Two-wire port pins
   input  wire logic                  two_wire_clock_pin_in,
   input  wire logic                  two_wire_data_pin_in,
   output logic                      two_wire_data_pin_out,
   output logic                      two_wire_data_pin_oe_n_out,
   input  wire logic                  two_wire_addr_select_pin_in,
   // Four-wire port pins
   input  wire logic                  four_wire_clock_pin_in,
   input  wire logic                  four_wire_select_n_pin_in,
   input  wire logic                  four_wire_data_in_pin_in,
   output logic                      four_wire_data_out_pin_out,
   output logic                      four_wire_data_out_pin_oe_n_out,
   // Third bus port
   input  wire logic                  third_req_in,
   input  wire logic                  third_we_in,
   input  wire ctrl_port_pkg::word_t  third_addr_in,
   input  wire ctrl_port_pkg::word_t  third_wdata_in,
   output logic                      third_done_out,
   output logic                      third_refused_out,
   output ctrl_port_pkg::word_t      third_rdata_out,
   // Status and pad control
   output logic                      addr_error_out,
   output logic                      addr_select_pulldown_en_out,
   output logic                      device_ready_out
);
   import ctrl_port_pkg::*;

   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic [1:0] sel_sync_reg;
   logic [1:0] sys_sync_reg;
   logic       scl_d_reg;
   logic       sda_d_reg;
   logic       scl;
   logic       sda;
   logic       scl_rise;
   logic       scl_fall;
   logic       tw_start;
   logic       tw_stop;

   word_t      four_wire_cfg_reg;
   word_t      two_wire_cfg_reg;
   word_t      pad_ctrl_two_reg;
   logic       addr_err_reg;

   logic [2:0] pend_reg;
   logic [2:0] issue;
   logic [2:0] ans_valid_reg;
   logic       ans_refused_reg;
   word_t      ans_rdata_reg;
   port_t      owner_reg;
   port_t      pick;
   logic       allowed;
   logic       sel_we;
   word_t      sel_addr;
   word_t      sel_wdata;
   word_t      rd_word;
   logic       do_write;
   logic       err_set;
   logic       err_clr;

   tw_state_t  tw_state_reg;
   logic [3:0] tw_bits_reg;
   logic [7:0] tw_shift_reg;
   logic [7:0] tw_hi_reg;
   word_t      tw_addr_reg;
   word_t      tw_wdata_reg;
   word_t      tw_tx_reg;
   logic       tw_we_reg;
   logic       tw_issue_reg;
   logic       tw_rx_byte_reg;
   logic       tw_ack_ok_reg;
   logic       tw_oe_n_reg;
   logic [7:0] tw_byte;

   logic [1:0] fw_tgl_sync_reg;
   logic       fw_tgl_d_reg;
   logic       fw_issue_reg;
   logic       fw_we_reg;
   word_t      fw_addr_reg;
   word_t      fw_wdata_reg;
   word_t      fw_rdata_reg;
   logic       fw_tgl;
   logic       fw_we;
   word_t      fw_addr;
   word_t      fw_wdata;

   logic       third_we_reg;
   word_t      third_addr_reg;
   word_t      third_wdata_reg;
   logic       ready_reg;

   // --------------------
   // Pin synchronisers
   // --------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         sel_sync_reg <= 2'h0;
         sys_sync_reg <= 2'h0;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end else if (clk_en_in) begin
         scl_sync_reg <= {scl_sync_reg[0], two_wire_clock_pin_in};
         sda_sync_reg <= {sda_sync_reg[0], two_wire_data_pin_in};
         sel_sync_reg <= {sel_sync_reg[0], two_wire_addr_select_pin_in};
         sys_sync_reg <= {sys_sync_reg[0], core_system_clock_active_in};
         scl_d_reg    <= scl_sync_reg[1];
         sda_d_reg    <= sda_sync_reg[1];
      end
   end

   assign scl      = scl_sync_reg[1];
   assign sda      = sda_sync_reg[1];
   assign scl_rise = scl & ~scl_d_reg;
   assign scl_fall = ~scl & scl_d_reg;
   assign tw_start = scl & scl_d_reg & sda_d_reg & ~sda;
   assign tw_stop  = scl & scl_d_reg & ~sda_d_reg & sda;
   assign tw_byte  = {tw_shift_reg[6:0], sda};

   // --------------------
   // Arbitration between the ports
   // --------------------
   assign issue = {third_req_in, fw_issue_reg, tw_issue_reg};

   always_comb begin
      pick      = PORT_NONE;
      sel_we    = 1'b0;
      sel_addr  = 16'h0000;
      sel_wdata = 16'h0000;
      if (pend_reg[0]) begin
         pick      = PORT_TWO;
         sel_we    = tw_we_reg;
         sel_addr  = tw_addr_reg;
         sel_wdata = tw_wdata_reg;
      end else if (pend_reg[1]) begin
         pick      = PORT_FOUR;
         sel_we    = fw_we_reg;
         sel_addr  = fw_addr_reg;
         sel_wdata = fw_wdata_reg;
      end else if (pend_reg[2]) begin
         pick      = PORT_THIRD;
         sel_we    = third_we_reg;
         sel_addr  = third_addr_reg;
         sel_wdata = third_wdata_reg;
      end
      allowed = sys_sync_reg[1] || owner_reg == PORT_NONE || owner_reg == pick;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         owner_reg <= PORT_NONE;
      end else if (clk_en_in) begin
         if (sys_sync_reg[1]) begin
            owner_reg <= PORT_NONE;
         end else if (owner_reg == PORT_NONE && pick != PORT_NONE) begin
            owner_reg <= pick;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pend_reg <= 3'h0;
      end else if (clk_en_in) begin
         for (int p = 0; p < 3; p++) begin
            pend_reg[p] <= issue[p] | (pend_reg[p] & (pick != port_t'(p)));
         end
      end
   end

   // --------------------
   // Register map
   // --------------------
   always_comb begin
      rd_word = 16'h0000;
      if (sel_addr == `REG_FOUR_WIRE_CFG) begin
         rd_word = four_wire_cfg_reg;
      end else if (sel_addr == `REG_TWO_WIRE_CFG) begin
         rd_word = two_wire_cfg_reg;
      end else if (sel_addr == `REG_ADDR_ERR) begin
         rd_word = {15'h0000, addr_err_reg};
      end else if (sel_addr == `REG_PAD_CTRL_TWO) begin
         rd_word = pad_ctrl_two_reg;
      end
   end

   assign do_write = pick != PORT_NONE && allowed && sel_we && addr_valid(sel_addr);
   assign err_set  = pick != PORT_NONE && allowed && !addr_valid(sel_addr);
   assign err_clr  = do_write && sel_addr == `REG_ADDR_ERR && sel_wdata[`ADDR_ERR_BIT];

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         four_wire_cfg_reg <= `FOUR_WIRE_CFG_RST;
         two_wire_cfg_reg  <= `TWO_WIRE_CFG_RST;
         pad_ctrl_two_reg  <= `PAD_CTRL_TWO_RST;
      end else if (clk_en_in && do_write) begin
         if (sel_addr == `REG_FOUR_WIRE_CFG) begin
            four_wire_cfg_reg <= sel_wdata;
         end else if (sel_addr == `REG_TWO_WIRE_CFG) begin
            two_wire_cfg_reg <= sel_wdata;
         end else if (sel_addr == `REG_PAD_CTRL_TWO) begin
            pad_ctrl_two_reg <= sel_wdata;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         addr_err_reg <= 1'b0;
      end else if (clk_en_in) begin
         addr_err_reg <= (addr_err_reg & ~err_clr) | err_set;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ans_valid_reg   <= 3'h0;
         ans_refused_reg <= 1'b0;
         ans_rdata_reg   <= 16'h0000;
         ready_reg       <= 1'b0;
      end else if (clk_en_in) begin
         ready_reg     <= 1'b1;
         ans_valid_reg <= 3'h0;
         if (pick != PORT_NONE) begin
            ans_valid_reg[pick] <= 1'b1;
            ans_refused_reg     <= ~allowed;
            ans_rdata_reg       <= (allowed && !sel_we) ? rd_word : 16'h0000;
         end
      end
   end

   // --------------------
   // Two-wire port
   // --------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tw_state_reg   <= TW_IDLE;
         tw_bits_reg    <= 4'h0;
         tw_shift_reg   <= 8'h00;
         tw_hi_reg      <= 8'h00;
         tw_addr_reg    <= 16'h0000;
         tw_wdata_reg   <= 16'h0000;
         tw_tx_reg      <= 16'h0000;
         tw_we_reg      <= 1'b0;
         tw_issue_reg   <= 1'b0;
         tw_rx_byte_reg <= 1'b1;
         tw_ack_ok_reg  <= 1'b0;
         tw_oe_n_reg    <= 1'b1;
      end else if (clk_en_in) begin
         tw_issue_reg <= 1'b0;
         if (ans_valid_reg[PORT_TWO]) begin
            if (tw_we_reg) begin
               tw_ack_ok_reg <= ~ans_refused_reg;
               tw_addr_reg   <= step_addr(tw_addr_reg, two_wire_cfg_reg[1:0]);
            end else begin
               tw_tx_reg <= ans_rdata_reg;
            end
         end
         if (tw_start) begin
            tw_state_reg <= TW_ID;
            tw_bits_reg  <= 4'h0;
            tw_oe_n_reg  <= 1'b1;
         end else if (tw_stop) begin
            tw_state_reg <= TW_IDLE;
            tw_oe_n_reg  <= 1'b1;
         end else if (tw_state_reg != TW_IDLE) begin
            if (scl_fall) begin
               if (tw_bits_reg == 4'h8) begin
                  tw_oe_n_reg <= ~(tw_rx_byte_reg & tw_ack_ok_reg);
               end else if (tw_state_reg == TW_READ_HI || tw_state_reg == TW_READ_LO) begin
                  tw_oe_n_reg <= tw_tx_reg[15];
                  tw_tx_reg   <= {tw_tx_reg[14:0], 1'b0};
               end else begin
                  tw_oe_n_reg <= 1'b1;
               end
            end
            if (scl_rise && tw_bits_reg == 4'h8) begin
               tw_bits_reg <= 4'h0;
               if (!tw_rx_byte_reg && sda) begin
                  tw_state_reg <= TW_IDLE;
               end else if (!tw_rx_byte_reg && tw_state_reg == TW_READ_HI) begin
                  tw_addr_reg  <= step_addr(tw_addr_reg, two_wire_cfg_reg[1:0]);
                  tw_issue_reg <= 1'b1;
               end
            end else if (scl_rise) begin
               tw_bits_reg  <= tw_bits_reg + 4'h1;
               tw_shift_reg <= tw_byte;
               if (tw_bits_reg == 4'h7) begin
                  tw_rx_byte_reg <= 1'b1;
                  case (tw_state_reg)
                     TW_ID: begin
                        if (tw_byte[7:1] == {`TWO_WIRE_ID_HIGH, sel_sync_reg[1]}) begin
                           tw_ack_ok_reg <= 1'b1;
                           if (tw_byte[0]) begin
                              tw_state_reg <= TW_READ_HI;
                              tw_we_reg    <= 1'b0;
                              tw_issue_reg <= 1'b1;
                           end else begin
                              tw_state_reg <= TW_ADDR_HI;
                           end
                        end else begin
                           tw_state_reg <= TW_IDLE;
                        end
                     end
                     TW_ADDR_HI: begin
                        tw_addr_reg[15:8] <= tw_byte;
                        tw_state_reg      <= TW_ADDR_LO;
                     end
                     TW_ADDR_LO: begin
                        tw_addr_reg[7:0] <= tw_byte;
                        tw_state_reg     <= TW_DATA_HI;
                     end
                     TW_DATA_HI: begin
                        tw_hi_reg    <= tw_byte;
                        tw_state_reg <= TW_DATA_LO;
                     end
                     TW_DATA_LO: begin
                        tw_wdata_reg <= {tw_hi_reg, tw_byte};
                        tw_we_reg    <= 1'b1;
                        tw_issue_reg <= 1'b1;
                        tw_state_reg <= TW_DATA_HI;
                     end
                     TW_READ_HI: begin
                        tw_rx_byte_reg <= 1'b0;
                        tw_state_reg   <= TW_READ_LO;
                     end
                     default: begin
                        tw_rx_byte_reg <= 1'b0;
                        tw_state_reg   <= TW_READ_HI;
                     end
                  endcase
               end
            end
         end
      end
   end

   // --------------------
   // Four-wire port and its crossing
   // --------------------
   four_wire_ctrl_port u_four_wire (
      .sclk_in        (four_wire_clock_pin_in),
      .select_n_in    (four_wire_select_n_pin_in),
      .mosi_in        (four_wire_data_in_pin_in),
      .miso_out       (four_wire_data_out_pin_out),
      .miso_oe_n_out  (four_wire_data_out_pin_oe_n_out),
      .rst_n_in       (rst_n_in),
      .wired_or_in    (four_wire_cfg_reg[`DRIVE_STYLE_BIT]),
      .step_in        (four_wire_cfg_reg[`STEP_MSB:`STEP_LSB]),
      .rdata_in       (fw_rdata_reg),
      .req_toggle_out (fw_tgl),
      .req_we_out     (fw_we),
      .req_addr_out   (fw_addr),
      .req_wdata_out  (fw_wdata)
   );

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         fw_tgl_sync_reg <= 2'h0;
         fw_tgl_d_reg    <= 1'b0;
         fw_issue_reg    <= 1'b0;
         fw_we_reg       <= 1'b0;
         fw_addr_reg     <= 16'h0000;
         fw_wdata_reg    <= 16'h0000;
         fw_rdata_reg    <= 16'h0000;
      end else if (clk_en_in) begin
         fw_tgl_sync_reg <= {fw_tgl_sync_reg[0], fw_tgl};
         fw_tgl_d_reg    <= fw_tgl_sync_reg[1];
         fw_issue_reg    <= fw_tgl_sync_reg[1] ^ fw_tgl_d_reg;
         if (fw_tgl_sync_reg[1] ^ fw_tgl_d_reg) begin
            fw_we_reg    <= fw_we;
            fw_addr_reg  <= fw_addr;
            fw_wdata_reg <= fw_wdata;
         end
         if (ans_valid_reg[PORT_FOUR]) begin
            fw_rdata_reg <= ans_rdata_reg;
         end
      end
   end

   // --------------------
   // Third bus port and outputs
   // --------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         third_we_reg    <= 1'b0;
         third_addr_reg  <= 16'h0000;
         third_wdata_reg <= 16'h0000;
      end else if (clk_en_in && third_req_in) begin
         third_we_reg    <= third_we_in;
         third_addr_reg  <= third_addr_in;
         third_wdata_reg <= third_wdata_in;
      end
   end

   assign third_done_out              = ans_valid_reg[PORT_THIRD];
   assign third_refused_out           = ans_refused_reg;
   assign third_rdata_out             = ans_rdata_reg;
   assign addr_error_out              = addr_err_reg;
   assign addr_select_pulldown_en_out = pad_ctrl_two_reg[`PULLDOWN_BIT];
   assign device_ready_out            = ready_reg;
   assign two_wire_data_pin_out       = 1'b0;
   assign two_wire_data_pin_oe_n_out  = tw_oe_n_reg;

endmodule // control_port_access_front_end

`default_nettype wire

// ### bench/four_wire_host.sv
// Four-wire host model clocking frames on its own 6 ns serial clock.
`timescale 1ns/1ps
`default_nettype none
module four_wire_host (
   output logic      sclk_out,
   output logic      sel_n_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   initial begin
      sclk_out = 0;
      sel_n_out = 0;
      mosi_out = 0;
      #1 sel_n_out = 1;
   end
   task automatic word(input logic [15:0] w, output logic [15:0] r);
      for (int i = 15; i >= 0; i--) begin
         mosi_out = w[i];
         #3 sclk_out = 1;
         r[i] = miso_in;
         if (i > 0) #3 sclk_out = 0;
      end
      #1100 sclk_out = 0;
   endtask
   task automatic frame(input logic [15:0] hdr, input logic [15:0] w, output logic [15:0] r);
      sel_n_out = 0;
      word(hdr, r);
      #3 word(w, r);
      sel_n_out = 1;
      #1100;
   endtask
endmodule // four_wire_host
`default_nettype wire

// ### bench/ctrl_port_asserts.sv
// Checker for the control port front end.
`timescale 1ns/1ps
`default_nettype none
module ctrl_port_asserts (
   input wire logic clk_in, rst_n_in, core_system_clock_active_in, two_wire_data_pin_in,
   input wire logic four_wire_select_n_pin_in, third_req_in, two_wire_data_pin_out,
   input wire logic four_wire_data_out_pin_oe_n_out, third_done_out, third_refused_out,
   input wire logic addr_error_out, addr_select_pulldown_en_out, device_ready_out,
   input wire ctrl_port_pkg::word_t third_rdata_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_sda_low; two_wire_data_pin_out == 1'b0; endproperty
   property p_ready; $rose(rst_n_in) |-> !device_ready_out && addr_select_pulldown_en_out
      && !addr_error_out ##1 device_ready_out; endproperty
   property p_done_pulse; third_done_out |=> !third_done_out; endproperty
   property p_refused_zero; third_done_out && third_refused_out |-> third_rdata_out == 0;
   endproperty
   property p_no_refuse; third_done_out && $past(core_system_clock_active_in, 4)
      && $past(core_system_clock_active_in, 5) |-> !third_refused_out; endproperty
   property p_answer; third_req_in && four_wire_select_n_pin_in |-> !third_done_out
      ##2 third_done_out; endproperty
   property p_err_hold; addr_error_out && !$past(third_req_in) && four_wire_select_n_pin_in
      && two_wire_data_pin_in |=> addr_error_out; endproperty
   property p_oe_idle; four_wire_select_n_pin_in && $past(four_wire_select_n_pin_in)
      |-> four_wire_data_out_pin_oe_n_out; endproperty
   a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
   a_ready: assert property (p_ready) else $error("bad reset values");
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   a_refused_zero: assert property (p_refused_zero) else $error("refused data");
   a_no_refuse: assert property (p_no_refuse) else $error("refused with clock");
   a_answer: assert property (p_answer) else $error("answer late");
   a_err_hold: assert property (p_err_hold) else $error("error dropped");
   a_oe_idle: assert property (p_oe_idle) else $error("output driven idle");
   c_refused: cover property (third_done_out && third_refused_out);
   c_err: cover property ($rose(addr_error_out));
   c_read: cover property ($fell(four_wire_data_out_pin_oe_n_out));
endmodule // ctrl_port_asserts
bind control_port_access_front_end ctrl_port_asserts chk (.*);
`default_nettype wire

// ### bench/tb.sv
// Testbench for the control port front end.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ctrl_port_pkg::*;
   logic clk_in = 0, rst_n_in = 1, act = 1, req = 0, we = 0, asel = 0;
   word_t addr = 0, wd = 0, rd, hr, v;
   logic sck, sel_n, mosi, miso, moe_n, done, refd, err, pd, rdy, sda_oe_n, sda_o;
   int mismatches = 0, num_checks = 0, mdl[int];
   always #50 clk_in = ~clk_in;
   four_wire_host host (.sclk_out(sck), .sel_n_out(sel_n), .mosi_out(mosi), .miso_in(miso));
   control_port_access_front_end uut (.clk_in, .rst_n_in, .clk_en_in(1'b1),
      .core_system_clock_active_in(act), .two_wire_clock_pin_in(1'b1),
      .two_wire_data_pin_in(sda_oe_n), .two_wire_data_pin_out(sda_o),
      .two_wire_data_pin_oe_n_out(sda_oe_n), .two_wire_addr_select_pin_in(asel),
      .four_wire_clock_pin_in(sck), .four_wire_select_n_pin_in(sel_n),
      .four_wire_data_in_pin_in(mosi), .four_wire_data_out_pin_out(miso),
      .four_wire_data_out_pin_oe_n_out(moe_n), .third_req_in(req), .third_we_in(we),
      .third_addr_in(addr), .third_wdata_in(wd), .third_done_out(done),
      .third_refused_out(refd), .third_rdata_out(rd), .addr_error_out(err),
      .addr_select_pulldown_en_out(pd), .device_ready_out(rdy));
   task automatic chk(string n, word_t e, word_t g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic acc(logic w, word_t a, word_t d, logic xr);
      @(negedge clk_in) {req, we, addr, wd} = {1'b1, w, a, d};
      @(negedge clk_in) req = 0;
      for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk_in);
      chk("done", 16'h1, 16'(done));
      chk("refused", 16'(xr), 16'(refd));
      if (!w) chk("rdata", (!xr && mdl.exists(a)) ? mdl[a] : 16'h0000, rd);
      if (!xr && !mdl.exists(a)) mdl[10] = 1;
      else if (w && !xr) mdl[a] = (a == 16'h000a) ? (d[0] ? 0 : mdl[10]) : d;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #3000000;
      mismatches++;
      conclude;
   end
   initial begin
      void'($urandom(19));
      #1 rst_n_in = 0;
      asel = 1'($urandom);
      mdl[8] = 16'h0011;
      mdl[9] = 16'h0001;
      mdl[10] = 0;
      mdl[16'h0c21] = 16'h0001;
      repeat (6) @(negedge clk_in);
      rst_n_in = 1;
      @(negedge clk_in);
      chk("ready", 16'h1, 16'(rdy));
      chk("pulldown", 16'h1, 16'(pd));
      foreach (mdl[a]) acc(0, 16'(a), 0, 0);
      acc(0, 16'h1000 + 16'($urandom % 256), 0, 0);
      chk("error", 16'h1, 16'(err));
      foreach (mdl[a]) if (a != 10) acc(1, 16'(a), 16'($urandom), 0);
      foreach (mdl[a]) acc(0, 16'(a), 0, 0);
      chk("pulldown", 16'(mdl[16'h0c21][0]), 16'(pd));
      acc(1, 16'h0008, 16'h0010, 0);
      v = 16'($urandom);
      host.frame(16'h0009, v, hr);
      mdl[9] = v;
      acc(0, 16'h0009, 0, 0);
      host.frame(16'h8c21, 0, hr);
      chk("serial read", mdl[16'h0c21], hr);
      @(negedge clk_in) act = 0;
      repeat (6) @(negedge clk_in);
      acc(1, 16'h0009, 16'h00a5, 0);
      host.frame(16'h0009, 16'h5a5a, hr);
      acc(0, 16'h0009, 0, 0);
      host.frame(16'h8009, 0, hr);
      chk("refused read", 16'h0000, hr);
      @(negedge clk_in) act = 1;
      repeat (6) @(negedge clk_in);
      host.frame(16'h0009, 16'h0f0f, hr);
      mdl[9] = 16'h0f0f;
      acc(0, 16'h0009, 0, 0);
      chk("error", 16'h1, 16'(err));
      acc(1, 16'h000a, 16'h0001, 0);
      acc(0, 16'h000a, 0, 0);
      chk("error", 16'h0, 16'(err));
      conclude;
   end
endmodule // tb
`default_nettype wire
